// *** scs_divider.sv ***
// Restartable divider giving a one-cycle enable every N clocks
`timescale 1ns/1ns
`default_nettype none
module scs_divider #(
	parameter int unsigned N = 16
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic clr_i,
	output logic tick_o
);
	logic [31:0] cnt_reg;

	// Restart lets a dwell or window start on a known edge
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || clr_i) begin
			cnt_reg <= 32'h0;
			tick_o <= 1'b0;
		end else if (cnt_reg == N - 1) begin
			cnt_reg <= 32'h0;
			tick_o <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 32'h1;
			tick_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** scs_pkg.sv ***
// Shared constants, types and decode helper for the scan and call sequencer
package scs_pkg;
	// Clock and time base
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned DWELL_S = 1;
	localparam int unsigned SEC_CYCLES = CLK_HZ * DWELL_S;
	localparam int unsigned BAUD_RATE = 300;
	localparam int unsigned BAUD_CYCLES = CLK_HZ / BAUD_RATE;
	localparam int unsigned HOLD_MIN = 2;
	localparam logic [6:0] HOLD_SECS = 7'(HOLD_MIN * 60);
	localparam logic [1:0] ALARM_SECS = 2'h2;
	// Sequence figures
	localparam logic [3:0] SCAN_CHAN = 4'h9;
	localparam logic [3:0] FIRST_CHAN = 4'h1;
	localparam logic [5:0] FIX_PKTS = 6'h3C;
	localparam logic [5:0] P1_PKTS = 6'h02;
	localparam logic [1:0] P1_PASSES = 2'h2;
	localparam logic [5:0] P2_PKTS = 6'h0F;
	localparam logic [6:0] QUAL_MAX = 7'h50;
	localparam logic [3:0] REPLY_FRAMES = 4'h8;
	localparam logic [3:0] LIMIT_MAX = 4'h8;
	localparam logic [3:0] LIMIT_OFF = 4'h0;
	localparam logic [7:0] BCAST_CODE = 8'h00;
	localparam logic [7:0] CODE_MAX = 8'hFF;
	// Register map, 3-bit word address
	localparam int AW = 3;
	localparam logic [2:0] A_LIMIT = 3'h0;
	localparam logic [2:0] A_CODE = 3'h1;
	localparam logic [2:0] A_THRESH = 3'h2;
	localparam logic [2:0] A_RXID = 3'h3;
	localparam logic [2:0] A_STATUS = 3'h4;
	localparam logic [2:0] A_CHAN = 3'h5;
	localparam logic [2:0] A_QUAL = 3'h6;
	// Values after reset
	localparam logic [3:0] RST_LIMIT = 4'h0;
	localparam logic [7:0] RST_CODE = 8'h01;
	localparam logic [6:0] RST_THRESH = 7'h46;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SCAN = 3'b001,
		ST_HOLD = 3'b010,
		ST_CLEAR = 3'b011,
		ST_SEND = 3'b100,
		ST_WIN = 3'b101,
		ST_REPLY = 3'b110
	} scs_state_t;

	typedef enum logic [1:0] {
		ED_NONE = 2'b00,
		ED_LIMIT = 2'b01,
		ED_CODE = 2'b10,
		ED_THRESH = 2'b11
	} scs_edit_t;

	// One-of-eight decode of the word address
	function automatic logic [7:0] scs_dec8(input logic [2:0] a);
		scs_dec8 = 8'h01 << a;
	endfunction
endpackage

// *** scs_remote_station.sv ***
// Remote station model on the far side of the modem link
`timescale 1ns/1ns
`default_nettype none
module scs_remote_station #(
	parameter int unsigned BIT = 4
) (
	input wire logic clock_i,
	input wire logic line_i,
	input wire logic line_en_i,
	input wire logic answer_i,
	input wire logic [7:0] id_i,
	output logic line_o
);
	int n_heard;
	logic [7:0] heard;
	// One frame: start, eight bits LSB first, stop; line rests at mark after
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clock_i) line_o <= f[i];
			repeat (BIT - 1) @(posedge clock_i);
		end
	endtask
	// Listener samples mid-bit; only frames sent while enabled count
	initial begin
		line_o = 1'b1;
		n_heard = 0;
		forever begin
			@(posedge clock_i);
			if (line_en_i && !line_i) begin
				repeat (BIT / 2) @(posedge clock_i);
				for (int i = 0; i < 8; i++) begin
					repeat (BIT) @(posedge clock_i);
					heard[i] = line_i;
				end
				repeat (BIT) @(posedge clock_i);
				n_heard++;
				// Acknowledge with own identity, and only a call naming this station
				if (answer_i && heard === id_i) begin
					repeat (2) @(posedge clock_i);
					repeat (8) send(id_i);
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** scs_seq_monitor.sv ***
// Checker of the sequencer's bus, modem and alarm outputs
`timescale 1ns/1ns
`default_nettype none
module scs_seq_monitor #(
	parameter int unsigned BAUD_CYCLES = 8
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [scs_pkg::AW-1:0] addr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic [7:0] receiver_code_switch_i,
	input wire logic tx_data_o,
	input wire logic tx_enable_o,
	input wire logic alarm_fast_o,
	input wire logic alarm_slow_o
);
	import scs_pkg::*;
	logic [15:0] en_cnt;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	// Length of the running burst, so frame length is judged without a long repetition
	always_ff @(posedge clock_i) begin
		if (!rst_n_i || !tx_enable_o) begin
			en_cnt <= 16'h0000;
		end else begin
			en_cnt <= en_cnt + 16'h0001;
		end
	end
	a_read_idle: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("read data not zero outside a read");
	a_switch_read: assert property (rd_i && addr_i == A_RXID |=>
		rdata_o == $past(receiver_code_switch_i))
		else $error("identity read differs from switches");
	a_limit_range: assert property (rd_i && addr_i == A_LIMIT |=> rdata_o <= 8'h08)
		else $error("scan limit above eight");
	a_thresh_range: assert property (rd_i && addr_i == A_THRESH |=> rdata_o <= 8'h50)
		else $error("threshold above eighty");
	a_line_idle: assert property (!tx_enable_o |-> tx_data_o)
		else $error("data line not idle while disabled");
	a_frame_start: assert property ($rose(tx_enable_o) |-> !tx_data_o)
		else $error("frame lacks start bit");
	a_frame_len: assert property ($fell(tx_enable_o) |-> en_cnt == 16'(10 * BAUD_CYCLES))
		else $error("frame not ten bit times");
	a_alarm_excl: assert property (!(alarm_fast_o && alarm_slow_o))
		else $error("both alarms at once");
	a_alarm_len: assert property ($rose(alarm_fast_o) |=> alarm_fast_o [*8])
		else $error("call alarm too short");
endmodule
bind scs_sequencer scs_seq_monitor #(.BAUD_CYCLES(BAUD_CYCLES)) u_scs_seq_monitor (
	.clock_i, .rst_n_i, .addr_i, .rd_i, .rdata_o, .receiver_code_switch_i,
	.tx_data_o, .tx_enable_o, .alarm_fast_o, .alarm_slow_o
);
`default_nettype wire

// *** scs_sequencer.sv ***
// Selective call and scan sequencer top: panel, calling sequences, registers
`timescale 1ns/1ns
`default_nettype none
module scs_sequencer
	import scs_pkg::*;
#(
	parameter int unsigned SEC_CYCLES = scs_pkg::SEC_CYCLES,
	parameter int unsigned BAUD_CYCLES = scs_pkg::BAUD_CYCLES
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [scs_pkg::AW-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic [3:0] chan_sel_i,
	input wire logic digit_up_i,
	input wire logic digit_dn_i,
	input wire logic tune_up_i,
	input wire logic tune_dn_i,
	input wire logic tune_btn_i,
	input wire logic ptt_i,
	input wire logic [7:0] receiver_code_switch_i,
	input wire logic rx_data_i,
	output logic tx_data_o,
	output logic tx_enable_o,
	output logic [3:0] channel_o,
	output logic alarm_fast_o,
	output logic alarm_slow_o,
	output logic [1:0] display_mode_o,
	output logic [7:0] display_value_o
);
	import scs_pkg::*;

	logic [18:0] pin_meta_reg;
	logic [18:0] pin_sync_reg;
	logic [3:0] sel_s;
	logic digit_up_s;
	logic digit_dn_s;
	logic tune_up_s;
	logic tune_dn_s;
	logic tune_btn_s;
	logic ptt_s;
	logic [7:0] rx_id_s;
	logic rx_s;
	logic tune_up_prev_reg;
	logic tune_dn_prev_reg;
	logic tune_btn_prev_reg;
	logic ptt_prev_reg;
	logic tune_up_rise;
	logic tune_dn_rise;
	logic tune_rise;
	logic [31:0] held_cnt_reg;
	logic long_hold_reg;
	scs_state_t state_reg;
	scs_edit_t edit_reg;
	logic [3:0] limit_reg;
	logic [7:0] code_reg;
	logic [6:0] thresh_reg;
	logic [3:0] orig_reg;
	logic [5:0] pkt_reg;
	logic [1:0] pass_reg;
	logic [3:0] reply_cnt_reg;
	logic seq_scan_reg;
	logic tx_start_reg;
	logic [7:0] tx_byte_reg;
	logic restart_reg;
	logic ev_fast_reg;
	logic ev_slow_reg;
	logic [6:0] hold_sec_reg;
	logic [1:0] alarm_sec_reg;
	logic [6:0] qual_reg;
	logic sec_tick;
	logic tx_done;
	logic rx_valid;
	logic [7:0] rx_byte;
	logic rx_ok;
	logic scan_on;
	logic calling;
	logic call_go;
	logic bcast_in;
	logic call_for_me;
	logic [5:0] per_chan;
	logic [7:0] wr_en;
	logic [7:0] rd_en;

	// Count of bits of a frame that agree with the expected code
	function automatic logic [3:0] good_bits(input logic [7:0] got, input logic [7:0] want);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'h0, ~(got[i] ^ want[i])};
		end
		good_bits = n;
	endfunction

	// Two-stage synchroniser for every panel pin and modem input
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			pin_meta_reg <= 19'h40000;
			pin_sync_reg <= 19'h40000;
		end else begin
			pin_meta_reg <= {rx_data_i, receiver_code_switch_i, ptt_i, tune_btn_i, tune_dn_i,
				tune_up_i, digit_dn_i, digit_up_i, chan_sel_i};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	assign sel_s = pin_sync_reg[3:0];
	assign digit_up_s = pin_sync_reg[4];
	assign digit_dn_s = pin_sync_reg[5];
	assign tune_up_s = pin_sync_reg[6];
	assign tune_dn_s = pin_sync_reg[7];
	assign tune_btn_s = pin_sync_reg[8];
	assign ptt_s = pin_sync_reg[9];
	assign rx_id_s = pin_sync_reg[17:10];
	assign rx_s = pin_sync_reg[18];

	// Edge detect on synchronised controls only
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			tune_up_prev_reg <= 1'b0;
			tune_dn_prev_reg <= 1'b0;
			tune_btn_prev_reg <= 1'b0;
			ptt_prev_reg <= 1'b0;
		end else begin
			tune_up_prev_reg <= tune_up_s;
			tune_dn_prev_reg <= tune_dn_s;
			tune_btn_prev_reg <= tune_btn_s;
			ptt_prev_reg <= ptt_s;
		end
	end

	assign tune_up_rise = tune_up_s & ~tune_up_prev_reg;
	assign tune_dn_rise = tune_dn_s & ~tune_dn_prev_reg;
	assign tune_rise = tune_btn_s & ~tune_btn_prev_reg;

	// One-second hold of the tune button gives a single pulse
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			held_cnt_reg <= 32'h0;
			long_hold_reg <= 1'b0;
		end else begin
			long_hold_reg <= 1'b0;
			if (!tune_btn_s) begin
				held_cnt_reg <= 32'h0;
			end else if (held_cnt_reg != SEC_CYCLES) begin
				held_cnt_reg <= held_cnt_reg + 32'h1;
				long_hold_reg <= (held_cnt_reg == SEC_CYCLES - 1);
			end
		end
	end

	// Limit off frees channel nine as a memory channel
	assign scan_on = (sel_s == SCAN_CHAN) && (limit_reg != LIMIT_OFF);
	assign calling = (state_reg == ST_CLEAR) || (state_reg == ST_SEND) || (state_reg == ST_WIN);
	assign call_go = tune_rise & digit_dn_s;
	assign bcast_in = rx_valid & rx_ok & (rx_byte == BCAST_CODE);
	// Identity zero never matches, so only 1..255 can be called
	assign call_for_me = rx_valid & rx_ok & (rx_byte == rx_id_s) & (rx_id_s != BCAST_CODE);
	assign per_chan = (pass_reg == P1_PASSES) ? P2_PKTS : P1_PKTS;

	scs_divider #(
		.N(SEC_CYCLES)
	) u_sec (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.clr_i(restart_reg),
		.tick_o(sec_tick)
	);

	scs_serial #(
		.BAUD(BAUD_CYCLES)
	) u_modem (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.tx_start_i(tx_start_reg),
		.tx_byte_i(tx_byte_reg),
		.tx_done_o(tx_done),
		.tx_data_o(tx_data_o),
		.tx_en_o(tx_enable_o),
		.rx_i(rx_s),
		.rx_valid_o(rx_valid),
		.rx_byte_o(rx_byte),
		.rx_ok_o(rx_ok)
	);

	// Calling, scanning, hold and reply sequencing
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			state_reg <= ST_IDLE;
			channel_o <= FIRST_CHAN;
			orig_reg <= FIRST_CHAN;
			pkt_reg <= 6'h00;
			pass_reg <= 2'h0;
			reply_cnt_reg <= 4'h0;
			seq_scan_reg <= 1'b0;
			tx_start_reg <= 1'b0;
			tx_byte_reg <= 8'h00;
			restart_reg <= 1'b0;
			ev_fast_reg <= 1'b0;
			ev_slow_reg <= 1'b0;
		end else begin
			tx_start_reg <= 1'b0;
			restart_reg <= 1'b0;
			ev_fast_reg <= 1'b0;
			ev_slow_reg <= 1'b0;
			if (long_hold_reg && (calling || state_reg == ST_HOLD)) begin
				state_reg <= scan_on ? ST_SCAN : ST_IDLE;
				channel_o <= orig_reg;
				restart_reg <= 1'b1;
			end else begin
				unique case (state_reg)
				ST_IDLE: begin
					channel_o <= sel_s;
					if (scan_on) begin
						state_reg <= ST_SCAN;
						channel_o <= FIRST_CHAN;
						restart_reg <= 1'b1;
					end else if (call_go) begin
						seq_scan_reg <= 1'b0;
						orig_reg <= sel_s;
						pkt_reg <= 6'h00;
						tx_byte_reg <= code_reg;
						tx_start_reg <= 1'b1;
						state_reg <= ST_SEND;
					end else if (bcast_in) begin
						ev_fast_reg <= 1'b1;
					end else if (call_for_me) begin
						reply_cnt_reg <= 4'h0;
						tx_byte_reg <= rx_id_s;
						tx_start_reg <= 1'b1;
						state_reg <= ST_REPLY;
					end
				end
				ST_SCAN: begin
					if (!scan_on) begin
						state_reg <= ST_IDLE;
					end else if (call_go) begin
						seq_scan_reg <= 1'b1;
						orig_reg <= channel_o;
						channel_o <= FIRST_CHAN;
						pkt_reg <= 6'h00;
						pass_reg <= 2'h0;
						restart_reg <= 1'b1;
						state_reg <= ST_CLEAR;
					end else if (bcast_in) begin
						ev_fast_reg <= 1'b1;
						orig_reg <= channel_o;
						restart_reg <= 1'b1;
						state_reg <= ST_HOLD;
					end else if (call_for_me) begin
						orig_reg <= channel_o;
						reply_cnt_reg <= 4'h0;
						tx_byte_reg <= rx_id_s;
						tx_start_reg <= 1'b1;
						state_reg <= ST_REPLY;
					end else if (sec_tick) begin
						// Dwell of one second, then next channel up to the limit
						channel_o <= (channel_o >= limit_reg) ? FIRST_CHAN : channel_o + 4'h1;
					end
				end
				ST_CLEAR: begin
					if (rx_valid) begin
						restart_reg <= 1'b1;
					end else if (sec_tick) begin
						tx_byte_reg <= code_reg;
						tx_start_reg <= 1'b1;
						state_reg <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (tx_done) begin
						restart_reg <= 1'b1;
						state_reg <= ST_WIN;
					end
				end
				ST_WIN: begin
					if (sec_tick) begin
						if (qual_reg >= thresh_reg) begin
							ev_fast_reg <= 1'b1;
							restart_reg <= 1'b1;
							state_reg <= seq_scan_reg ? ST_HOLD : ST_IDLE;
						end else if (!seq_scan_reg) begin
							if (pkt_reg == FIX_PKTS - 6'h01) begin
								ev_slow_reg <= 1'b1;
								state_reg <= ST_IDLE;
							end else begin
								pkt_reg <= pkt_reg + 6'h01;
								tx_start_reg <= 1'b1;
								state_reg <= ST_SEND;
							end
						end else if (pkt_reg != per_chan - 6'h01) begin
							pkt_reg <= pkt_reg + 6'h01;
							tx_start_reg <= 1'b1;
							state_reg <= ST_SEND;
						end else begin
							pkt_reg <= 6'h00;
							if (channel_o < limit_reg) begin
								channel_o <= channel_o + 4'h1;
								tx_start_reg <= 1'b1;
								state_reg <= ST_SEND;
							end else if (pass_reg != P1_PASSES) begin
								channel_o <= FIRST_CHAN;
								pass_reg <= pass_reg + 2'h1;
								tx_start_reg <= 1'b1;
								state_reg <= ST_SEND;
							end else begin
								ev_slow_reg <= 1'b1;
								channel_o <= orig_reg;
								restart_reg <= 1'b1;
								state_reg <= ST_SCAN;
							end
						end
					end
				end
				ST_HOLD: begin
					if (sec_tick && hold_sec_reg == HOLD_SECS - 7'h01) begin
						restart_reg <= 1'b1;
						state_reg <= scan_on ? ST_SCAN : ST_IDLE;
					end
				end
				ST_REPLY: begin
					// A burst of frames lets the caller measure the channel
					if (tx_done) begin
						if (reply_cnt_reg == REPLY_FRAMES - 4'h1) begin
							ev_fast_reg <= 1'b1;
							restart_reg <= 1'b1;
							state_reg <= scan_on ? ST_HOLD : ST_IDLE;
						end else begin
							reply_cnt_reg <= reply_cnt_reg + 4'h1;
							tx_start_reg <= 1'b1;
						end
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
				endcase
			end
		end
	end

	// Hold timer in seconds; any transmission restarts it
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			hold_sec_reg <= 7'h00;
		end else if (restart_reg || (ptt_s && !ptt_prev_reg) || tx_start_reg) begin
			hold_sec_reg <= 7'h00;
		end else if (state_reg == ST_HOLD && sec_tick) begin
			hold_sec_reg <= hold_sec_reg + 7'h01;
		end
	end

	// Link quality: agreeing bits plus one plus a good stop bit, capped at 80
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			qual_reg <= 7'h00;
		end else if (state_reg == ST_SEND) begin
			qual_reg <= 7'h00;
		end else if (state_reg == ST_WIN && rx_valid) begin
			if (qual_reg + {3'h0, good_bits(rx_byte, code_reg)} + 7'h02 > QUAL_MAX) begin
				qual_reg <= QUAL_MAX;
			end else begin
				qual_reg <= qual_reg + {3'h0, good_bits(rx_byte, code_reg)} + {6'h00, rx_ok} + 7'h01;
			end
		end
	end

	// Alarm level lasts until the ALARM_SECS-th tick of the seconds divider; newest event wins
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			alarm_fast_o <= 1'b0;
			alarm_slow_o <= 1'b0;
			alarm_sec_reg <= 2'h0;
		end else if (ev_fast_reg || ev_slow_reg) begin
			alarm_fast_o <= ev_fast_reg;
			alarm_slow_o <= ev_slow_reg;
			alarm_sec_reg <= 2'h0;
		end else if ((alarm_fast_o || alarm_slow_o) && sec_tick) begin
			if (alarm_sec_reg == ALARM_SECS - 2'h1) begin
				alarm_fast_o <= 1'b0;
				alarm_slow_o <= 1'b0;
			end else begin
				alarm_sec_reg <= alarm_sec_reg + 2'h1;
			end
		end
	end

	assign wr_en = wr_i ? scs_dec8(addr_i) : 8'h00;
	assign rd_en = rd_i ? scs_dec8(addr_i) : 8'h00;

	// Panel editing modes and stored settings; bus write has priority
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			edit_reg <= ED_NONE;
			limit_reg <= RST_LIMIT;
			code_reg <= RST_CODE;
			thresh_reg <= RST_THRESH;
		end else begin
			if (digit_up_s) begin
				edit_reg <= ED_LIMIT;
			end else if (edit_reg == ED_THRESH && tune_btn_s) begin
				edit_reg <= ED_THRESH;
			end else if (digit_dn_s) begin
				// The press that enters threshold edit also starts a call, which the same hold aborts
				edit_reg <= (edit_reg == ED_CODE && long_hold_reg) ? ED_THRESH : ED_CODE;
			end else begin
				edit_reg <= ED_NONE;
			end
			if (wr_en[A_LIMIT]) begin
				limit_reg <= (wdata_i[3:0] > LIMIT_MAX) ? LIMIT_MAX : wdata_i[3:0];
			end else if (edit_reg == ED_LIMIT && tune_up_rise && limit_reg != LIMIT_MAX) begin
				limit_reg <= limit_reg + 4'h1;
			end else if (edit_reg == ED_LIMIT && tune_dn_rise && limit_reg != LIMIT_OFF) begin
				limit_reg <= limit_reg - 4'h1;
			end
			if (wr_en[A_CODE]) begin
				code_reg <= wdata_i;
			end else if (edit_reg == ED_CODE && tune_up_rise && code_reg != CODE_MAX) begin
				code_reg <= code_reg + 8'h01;
			end else if (edit_reg == ED_CODE && tune_dn_rise && code_reg != BCAST_CODE) begin
				code_reg <= code_reg - 8'h01;
			end
			if (wr_en[A_THRESH]) begin
				thresh_reg <= (wdata_i[6:0] > QUAL_MAX) ? QUAL_MAX : wdata_i[6:0];
			end else if (edit_reg == ED_THRESH && tune_up_rise && thresh_reg != QUAL_MAX) begin
				thresh_reg <= thresh_reg + 7'h01;
			end else if (edit_reg == ED_THRESH && tune_dn_rise && thresh_reg != 7'h00) begin
				thresh_reg <= thresh_reg - 7'h01;
			end
		end
	end

	// Display follows the active editing mode
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			display_mode_o <= ED_NONE;
			display_value_o <= 8'h00;
		end else begin
			display_mode_o <= edit_reg;
			unique case (edit_reg)
			ED_LIMIT: display_value_o <= {4'h0, limit_reg};
			ED_CODE: display_value_o <= code_reg;
			ED_THRESH: display_value_o <= {1'b0, thresh_reg};
			ED_NONE: display_value_o <= 8'h00;
			endcase
		end
	end

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			rdata_o <= 8'h00;
		end else begin
			rdata_o <= 8'h00;
			if (rd_en[A_LIMIT]) rdata_o <= {4'h0, limit_reg};
			if (rd_en[A_CODE]) rdata_o <= code_reg;
			if (rd_en[A_THRESH]) rdata_o <= {1'b0, thresh_reg};
			if (rd_en[A_RXID]) rdata_o <= rx_id_s;
			if (rd_en[A_STATUS]) rdata_o <= {alarm_slow_o, alarm_fast_o, scan_on, 2'h0, state_reg};
			if (rd_en[A_CHAN]) rdata_o <= {4'h0, channel_o};
			if (rd_en[A_QUAL]) rdata_o <= {1'b0, qual_reg};
		end
	end
endmodule
`default_nettype wire

// *** scs_sequencer_bench.sv ***
// Self-checking bench for the selective call and scan sequencer
`timescale 1ns/1ns
`default_nettype none
module scs_sequencer_bench;
	import scs_pkg::*;
	localparam int unsigned T_SEC = 400;
	localparam int unsigned T_BIT = 4;
	logic clock_i, rst_n_i, wr_i, rd_i, digit_up_i, digit_dn_i, tune_up_i, tune_dn_i, tune_btn_i;
	logic rx_data_i, answer, tx_data_o, tx_enable_o, alarm_fast_o, alarm_slow_o;
	logic [1:0] display_mode_o;
	logic [2:0] addr_i;
	logic [3:0] chan_sel_i, channel_o;
	logic [7:0] wdata_i, rdata_o, remote_id, display_value_o;
	int n_errors, n_tests, cyc, base;
	scs_sequencer #(.SEC_CYCLES(T_SEC), .BAUD_CYCLES(T_BIT)) u_scs_sequencer (
		.clock_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .chan_sel_i,
		.digit_up_i, .digit_dn_i, .tune_up_i, .tune_dn_i, .tune_btn_i, .ptt_i(1'b0),
		.receiver_code_switch_i(8'h2A), .rx_data_i, .tx_data_o, .tx_enable_o,
		.channel_o, .alarm_fast_o, .alarm_slow_o, .display_mode_o, .display_value_o
	);
	scs_remote_station #(.BIT(T_BIT)) u_scs_remote_station (
		.clock_i, .line_i(tx_data_o), .line_en_i(tx_enable_o), .answer_i(answer),
		.id_i(remote_id), .line_o(rx_data_i)
	);
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 chk(nm, 16'(e), 16'(rdata_o));
	endtask
	function automatic logic sig(input int s);
		return s == 0 ? tx_enable_o : (s == 1 ? alarm_fast_o : alarm_slow_o);
	endfunction
	task automatic wait_for(input int s, input int n, input logic v, input string nm);
		int k;
		k = 0;
		while (sig(s) !== v && k < n) begin
			@(posedge clock_i);
			k++;
		end
		chk(nm, 16'(v), 16'(sig(s)));
	endtask
	task automatic call(input logic [3:0] ch);
		base = u_scs_remote_station.n_heard;
		chan_sel_i <= ch;
		digit_dn_i <= 1'b1;
		repeat (6) @(posedge clock_i);
		tune_btn_i <= 1'b1;
		repeat (6) @(posedge clock_i);
		tune_btn_i <= 1'b0;
		digit_dn_i <= 1'b0;
	endtask
	task automatic t_regs;
		rd(A_LIMIT, 8'(RST_LIMIT), "limit");
		rd(A_THRESH, 8'(RST_THRESH), "thresh");
		rd(A_RXID, 8'h2A, "rxid");
		rd(3'h7, 8'h00, "unmapped");
		wr(A_LIMIT, 8'h0C);
		rd(A_LIMIT, 8'(LIMIT_MAX), "limit clamp");
		wr(A_THRESH, 8'h63);
		rd(A_THRESH, 8'(QUAL_MAX), "thresh clamp");
		wr(A_RXID, 8'h11);
		rd(A_RXID, 8'h2A, "rxid ro");
		wr(A_THRESH, 8'(RST_THRESH));
	endtask
	task automatic t_edit;
		wr(A_LIMIT, 8'h03);
		digit_up_i <= 1'b1;
		repeat (6) @(posedge clock_i);
		chk("mode", 16'(ED_LIMIT), 16'(display_mode_o));
		chk("shown", 16'h0003, 16'(display_value_o));
		tune_up_i <= 1'b1;
		repeat (6) @(posedge clock_i);
		tune_up_i <= 1'b0;
		repeat (6) @(posedge clock_i);
		chk("shown up", 16'h0004, 16'(display_value_o));
		tune_dn_i <= 1'b1;
		repeat (6) @(posedge clock_i);
		tune_dn_i <= 1'b0;
		digit_up_i <= 1'b0;
		repeat (6) @(posedge clock_i);
		chk("mode off", 16'(ED_NONE), 16'(display_mode_o));
		rd(A_LIMIT, 8'h03, "limit step");
	endtask
	// Incoming calls: own code answered with eight frames, other codes ignored, broadcast alarms without reply
	task automatic t_call_in;
		base = u_scs_remote_station.n_heard;
		u_scs_remote_station.send(8'h2A);
		wait_for(0, 200, 1'b1, "reply");
		repeat (400) @(posedge clock_i);
		chk("reply frames", 16'(base + 8), 16'(u_scs_remote_station.n_heard));
		u_scs_remote_station.send(8'h15);
		repeat (200) @(posedge clock_i);
		chk("no reply", 16'(base + 8), 16'(u_scs_remote_station.n_heard));
		// Reply alarm must be over, or the broadcast alarm could not be seen to rise
		wait_for(1, 2 * T_SEC + 50, 1'b0, "reply alarm end");
		u_scs_remote_station.send(BCAST_CODE);
		wait_for(1, 200, 1'b1, "bcast alarm");
		chk("bcast quiet", 16'h0000, 16'(tx_enable_o));
		wait_for(1, 2 * T_SEC + 50, 1'b0, "alarm end");
	endtask
	task automatic t_fixed;
		wr(A_CODE, 8'h5C);
		remote_id <= 8'h5C;
		answer <= 1'b1;
		call(4'h3);
		wait_for(1, 3 * T_SEC, 1'b1, "ack alarm");
		chk("no err alarm", 16'h0000, 16'(alarm_slow_o));
		chk("call code", 16'h005C, 16'(u_scs_remote_station.heard));
		wait_for(1, 2 * T_SEC + 50, 1'b0, "alarm end");
	endtask
	// Scan call answered on the first channel; a long press then ends the hold
	task automatic t_scan;
		wr(A_LIMIT, 8'h02);
		call(SCAN_CHAN);
		wait_for(1, 3 * T_SEC, 1'b1, "scan ack");
		chk("hold chan", 16'(FIRST_CHAN), 16'(channel_o));
		wait_for(1, 2 * T_SEC + 50, 1'b0, "alarm end");
		rd(A_STATUS, 8'h22, "hold state");
		tune_btn_i <= 1'b1;
		repeat (T_SEC + 20) @(posedge clock_i);
		tune_btn_i <= 1'b0;
		rd(A_STATUS, 8'h21, "abort");
		repeat (T_SEC + T_SEC / 2) @(posedge clock_i);
		chk("dwell step", 16'h0002, 16'(channel_o));
	endtask
	// Unanswered call on position nine with scan off runs the full fixed sequence
	task automatic t_fail;
		answer <= 1'b0;
		wr(A_LIMIT, 8'h00);
		call(4'h9);
		wait_for(2, 60 * (T_SEC + 60) + 200, 1'b1, "err alarm");
		chk("packets", 16'(base + 60), 16'(u_scs_remote_station.n_heard));
	endtask
	task automatic test_done;
		if (n_errors == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end
	// Hang guard well above the longest expected run
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			n_errors++;
			test_done;
		end
	end
	initial begin
		{wr_i, rd_i, digit_up_i, digit_dn_i, tune_up_i, tune_dn_i, tune_btn_i, answer} = '0;
		{addr_i, wdata_i, remote_id, cyc, n_errors, n_tests} = '0;
		chan_sel_i = 4'h3;
		rst_n_i = 1'b0;
		repeat (20) @(posedge clock_i);
		rst_n_i <= 1'b1;
		t_regs;
		t_edit;
		t_call_in;
		t_fixed;
		t_scan;
		t_fail;
		test_done;
	end
endmodule
`default_nettype wire

// *** scs_serial.sv ***
// 8N1 serial framer for the 300-baud modem data lines
`timescale 1ns/1ns
`default_nettype none
module scs_serial #(
	parameter int unsigned BAUD = 166666
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic tx_start_i,
	input wire logic [7:0] tx_byte_i,
	output logic tx_done_o,
	output logic tx_data_o,
	output logic tx_en_o,
	input wire logic rx_i,
	output logic rx_valid_o,
	output logic [7:0] rx_byte_o,
	output logic rx_ok_o
);
	logic [31:0] tcnt_reg;
	logic [3:0] tn_reg;
	logic [8:0] tsh_reg;
	logic [31:0] rcnt_reg;
	logic [3:0] rn_reg;
	logic rbusy_reg;

	// Transmit; enable frames the modulated burst, line idles at mark
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			tcnt_reg <= 32'h0;
			tn_reg <= 4'h0;
			tsh_reg <= 9'h1FF;
			tx_data_o <= 1'b1;
			tx_en_o <= 1'b0;
			tx_done_o <= 1'b0;
		end else begin
			tx_done_o <= 1'b0;
			if (!tx_en_o) begin
				if (tx_start_i) begin
					tsh_reg <= {1'b1, tx_byte_i};
					tx_data_o <= 1'b0;
					tx_en_o <= 1'b1;
					tcnt_reg <= 32'h0;
					tn_reg <= 4'h0;
				end
			end else if (tcnt_reg == BAUD - 1) begin
				tcnt_reg <= 32'h0;
				if (tn_reg == 4'h9) begin
					tx_en_o <= 1'b0;
					tx_done_o <= 1'b1;
					tx_data_o <= 1'b1;
				end else begin
					tn_reg <= tn_reg + 4'h1;
					tx_data_o <= tsh_reg[0];
					tsh_reg <= {1'b1, tsh_reg[8:1]};
				end
			end else begin
				tcnt_reg <= tcnt_reg + 32'h1;
			end
		end
	end

	// Receive; samples mid-bit, a false start bit is dropped
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			rcnt_reg <= 32'h0;
			rn_reg <= 4'h0;
			rbusy_reg <= 1'b0;
			rx_byte_o <= 8'h00;
			rx_valid_o <= 1'b0;
			rx_ok_o <= 1'b0;
		end else begin
			rx_valid_o <= 1'b0;
			if (!rbusy_reg) begin
				if (!rx_i) begin
					rbusy_reg <= 1'b1;
					rcnt_reg <= BAUD / 2;
					rn_reg <= 4'h0;
				end
			end else if (rcnt_reg == BAUD - 1) begin
				rcnt_reg <= 32'h0;
				rn_reg <= rn_reg + 4'h1;
				if (rn_reg == 4'h0 && rx_i) begin
					rbusy_reg <= 1'b0;
				end else if (rn_reg == 4'h9) begin
					rbusy_reg <= 1'b0;
					rx_valid_o <= 1'b1;
					rx_ok_o <= rx_i;
				end else if (rn_reg != 4'h0) begin
					rx_byte_o <= {rx_i, rx_byte_o[7:1]};
				end
			end else begin
				rcnt_reg <= rcnt_reg + 32'h1;
			end
		end
	end
endmodule
`default_nettype wire
